// file: core/deac_pkg.sv
package deac_pkg;
    localparam int DEAC_ADDR_W = 18;
    localparam int DEAC_DATA_W = 32;
    localparam int DEAC_IDX_W = 16;
    localparam logic [DEAC_IDX_W-1:0] DEAC_IDX_POWER_SAVE = 16'h8008;
    localparam logic [DEAC_IDX_W-1:0] DEAC_IDX_DISPLAY_ON = 16'h8009;
    localparam logic [DEAC_IDX_W-1:0] DEAC_IDX_ATTRIBUTES = 16'h800a;
    localparam logic [DEAC_IDX_W-1:0] DEAC_IDX_CONFIG = 16'h8030;
    localparam logic [DEAC_IDX_W-1:0] DEAC_IDX_STATUS = 16'h8031;
    localparam int DEAC_PS_EN_BIT = 0;
    localparam int DEAC_DISP_EN_BIT = 0;
    localparam int DEAC_CFG_INDIRECT_BIT = 0;
    localparam int DEAC_CFG_DUAL_BIT = 3;
    localparam int DEAC_STAT_PS_BIT = 0;
    localparam int DEAC_STAT_PEND_BIT = 1;
    localparam int DEAC_STAT_CURSOR_BIT = 2;
    localparam int DEAC_ATTR_L3_LSB = 6;
    localparam int DEAC_ATTR_L2_LSB = 4;
    localparam int DEAC_ATTR_L1_LSB = 2;
    localparam int DEAC_ATTR_CUR_LSB = 0;
    localparam logic [1:0] DEAC_FLASH_BLANK = 2'h0;
    localparam logic [1:0] DEAC_FLASH_STEADY = 2'h1;
    localparam logic [1:0] DEAC_FLASH_SLOW = 2'h2;
    localparam logic [1:0] DEAC_FLASH_FAST = 2'h3;
    localparam logic DEAC_PS_RESET = 1'b1;
    localparam logic DEAC_DISP_RESET = 1'b0;
    localparam logic [7:0] DEAC_ATTR_RESET = 8'h00;
    localparam logic [7:0] DEAC_CFG_RESET = 8'h00;
    localparam int DEAC_FAST_DIV = 4;
    localparam int DEAC_SLOW_DIV = 32;
    localparam int DEAC_CURSOR_SLOW_DIV = 64;
    localparam int DEAC_CURSOR_ON_PCT = 70;
    localparam int DEAC_PCT_FULL = 100;
    localparam int DEAC_CURSOR_W = 16;

    typedef enum logic [1:0] {
        DEAC_PS_SAVE = 2'h0,
        DEAC_PS_PENDING = 2'h1,
        DEAC_PS_ACTIVE = 2'h3
    } deac_ps_state_type;

    function automatic logic [DEAC_ADDR_W-1:0] deac_byte_addr(input logic [DEAC_IDX_W-1:0] idx);
        deac_byte_addr = {idx, 2'h0};
    endfunction
endpackage

// file: core/deac_flash_if.sv
`timescale 1ns/1ps
`default_nettype none
interface deac_flash_if;
    logic fast_on;
    logic slow_on;
    logic cursor_slow_on;
    logic cursor_vslow_on;
    modport gen (output fast_on, output slow_on, output cursor_slow_on, output cursor_vslow_on);
    modport user (input fast_on, input slow_on, input cursor_slow_on, input cursor_vslow_on);
endinterface
`default_nettype wire

// file: core/deac_flash_gen.sv
`timescale 1ns/1ps
`default_nettype none
module deac_flash_gen
    import deac_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_tick,
    deac_flash_if.gen flash
);
    if (CNT_W < $clog2(DEAC_CURSOR_SLOW_DIV)) begin : g_check
        $error("deac_flash_gen: CNT_W too small for the slowest flash period");
    end

    logic [CNT_W-1:0] frame_count;

    // Visible for the first half of each flash period
    function automatic logic half_on(input logic [CNT_W-1:0] c, input int div);
        half_on = (int'(c) % div) < (div / 2);
    endfunction

    // Visible while the phase is within the on share of the period
    function automatic logic duty_on(input logic [CNT_W-1:0] c, input int div);
        duty_on = ((int'(c) % div) * DEAC_PCT_FULL) < (div * DEAC_CURSOR_ON_PCT);
    endfunction

    // Free running frame counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_count <= '0;
        end else if (frame_tick) begin
            frame_count <= frame_count + 1'b1;
        end
    end

    assign flash.fast_on = half_on(frame_count, DEAC_FAST_DIV);
    assign flash.slow_on = half_on(frame_count, DEAC_SLOW_DIV);
    assign flash.cursor_slow_on = duty_on(frame_count, DEAC_SLOW_DIV);
    assign flash.cursor_vslow_on = duty_on(frame_count, DEAC_CURSOR_SLOW_DIV);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_count_step: assert property (frame_tick |=> frame_count == $past(frame_count) + 1'b1)
        else $error("frame counter did not advance on frame tick");
    a_count_hold: assert property (!frame_tick |=> frame_count == $past(frame_count))
        else $error("frame counter moved without frame tick");
endmodule
`default_nettype wire

// file: core/deac_display_ctrl.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module deac_display_ctrl
    import deac_pkg::*;
#(
    parameter int ADDR_W = DEAC_ADDR_W,
    parameter int CNT_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DEAC_DATA_W-1:0] pwdata,
    output logic [DEAC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_tick,
    input wire logic mem_write,
    input wire logic mem_read,
    input wire logic cursor_load,
    input wire logic [DEAC_CURSOR_W-1:0] cursor_load_addr,
    input wire logic cmd_display_switch,
    input wire logic cmd_display_on,
    input wire logic [7:0] cmd_param,
    output logic display_on,
    output logic power_save_active,
    output logic [3:0] block_visible,
    output logic cursor_visible,
    output logic cursor_enabled,
    output logic [DEAC_CURSOR_W-1:0] cursor_addr
);
    if (ADDR_W < DEAC_ADDR_W) begin : g_check
        $error("deac_display_ctrl: ADDR_W too narrow for the register map");
    end

    deac_flash_if flash ();

    deac_flash_gen #(
        .CNT_W(CNT_W)
    ) u_flash (
        .clk(clk),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .flash(flash)
    );

    logic power_save_bit;
    logic display_enable;
    logic [7:0] attributes;
    logic [7:0] config_reg;
    deac_ps_state_type ps_state;
    logic [7:0] next_attributes;
    logic next_display_enable;
    logic [DEAC_DATA_W-1:0] next_prdata;

    logic apb_setup;
    logic apb_wr;
    logic hit_ps;
    logic hit_disp;
    logic hit_attr;
    logic hit_cfg;
    logic hit_stat;
    logic mapped;
    logic ps_set_wr;
    logic ps_clr_wr;
    logic indirect_mode;
    logic dual_panel;
    logic cmd_take;
    logic display_live;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [DEAC_IDX_W-1:0] idx);
        addr_hit = (a[DEAC_ADDR_W-1:0] == deac_byte_addr(idx))
            && (a[ADDR_W-1:DEAC_ADDR_W-1] == (ADDR_W-DEAC_ADDR_W+1)'(a[DEAC_ADDR_W-1]));
    endfunction

    // Visibility of a screen block from its two-bit attribute field
    function automatic logic layer_show(input logic [1:0] f, input logic fast, input logic slow);
        case (f)
            DEAC_FLASH_BLANK: layer_show = 1'b0;
            DEAC_FLASH_STEADY: layer_show = 1'b1;
            DEAC_FLASH_SLOW: layer_show = slow;
            DEAC_FLASH_FAST: layer_show = fast;
            default: layer_show = 1'b0;
        endcase
    endfunction

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign hit_ps = addr_hit(paddr, DEAC_IDX_POWER_SAVE);
    assign hit_disp = addr_hit(paddr, DEAC_IDX_DISPLAY_ON);
    assign hit_attr = addr_hit(paddr, DEAC_IDX_ATTRIBUTES);
    assign hit_cfg = addr_hit(paddr, DEAC_IDX_CONFIG);
    assign hit_stat = addr_hit(paddr, DEAC_IDX_STATUS);
    assign mapped = hit_ps || hit_disp || hit_attr || hit_cfg || hit_stat;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign ps_set_wr = apb_wr && hit_ps && pwdata[DEAC_PS_EN_BIT];
    assign ps_clr_wr = apb_wr && hit_ps && !pwdata[DEAC_PS_EN_BIT];
    assign indirect_mode = config_reg[DEAC_CFG_INDIRECT_BIT];
    assign dual_panel = config_reg[DEAC_CFG_DUAL_BIT];
    assign cmd_take = cmd_display_switch && indirect_mode;
    assign display_live = display_enable && (ps_state == DEAC_PS_ACTIVE);

    // Power save enable bit, set from reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_save_bit <= DEAC_PS_RESET;
        end else if (apb_wr && hit_ps) begin
            power_save_bit <= pwdata[DEAC_PS_EN_BIT];
        end
    end

    // Power save sequencing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ps_state <= DEAC_PS_SAVE;
        end else begin
            case (ps_state)
                DEAC_PS_SAVE: begin
                    if (ps_clr_wr) begin
                        ps_state <= indirect_mode ? DEAC_PS_ACTIVE : DEAC_PS_PENDING;
                    end
                end
                DEAC_PS_PENDING: begin
                    if (ps_set_wr) begin
                        ps_state <= DEAC_PS_SAVE;
                    end else if (apb_wr) begin
                        ps_state <= DEAC_PS_ACTIVE;
                    end
                end
                DEAC_PS_ACTIVE: begin
                    if (ps_set_wr) begin
                        ps_state <= DEAC_PS_SAVE;
                    end
                end
                default: begin
                    ps_state <= DEAC_PS_SAVE;
                end
            endcase
        end
    end

    // Display enable: power save entry wins over any other source
    always_comb begin
        next_display_enable = display_enable;
        if (ps_set_wr) begin
            next_display_enable = 1'b0;
        end else if (apb_wr && hit_disp) begin
            next_display_enable = pwdata[DEAC_DISP_EN_BIT];
        end else if (cmd_take) begin
            next_display_enable = cmd_display_on;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            display_enable <= DEAC_DISP_RESET;
        end else begin
            display_enable <= next_display_enable;
        end
    end

    // Attributes: a memory write re-enables a blank cursor, even over a clearing write
    always_comb begin
        next_attributes = attributes;
        if (apb_wr && hit_attr) begin
            next_attributes = pwdata[7:0];
        end else if (cmd_take) begin
            next_attributes = cmd_param;
        end
        if (mem_write && next_attributes[DEAC_ATTR_CUR_LSB+:2] == DEAC_FLASH_BLANK) begin
            next_attributes[DEAC_ATTR_CUR_LSB+:2] = DEAC_FLASH_STEADY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            attributes <= DEAC_ATTR_RESET;
        end else begin
            attributes <= next_attributes;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            config_reg <= DEAC_CFG_RESET;
        end else if (apb_wr && hit_cfg) begin
            config_reg <= pwdata[7:0];
        end
    end

    // Cursor position follows every memory access, except in a cycle with a cursor load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cursor_addr <= '0;
        end else if (cursor_load) begin
            cursor_addr <= cursor_load_addr;
        end else if (mem_write || mem_read) begin
            cursor_addr <= cursor_addr + 1'b1;
        end
    end

    // Read data is captured in the setup phase
    always_comb begin
        next_prdata = '0;
        if (hit_ps) begin
            next_prdata[DEAC_PS_EN_BIT] = power_save_bit;
        end
        if (hit_disp) begin
            next_prdata[DEAC_DISP_EN_BIT] = display_enable;
        end
        if (hit_attr) begin
            next_prdata[7:0] = attributes;
        end
        if (hit_cfg) begin
            next_prdata[7:0] = config_reg;
        end
        if (hit_stat) begin
            next_prdata[DEAC_STAT_PS_BIT] = ps_state != DEAC_PS_ACTIVE;
            next_prdata[DEAC_STAT_PEND_BIT] = ps_state == DEAC_PS_PENDING;
            next_prdata[DEAC_STAT_CURSOR_BIT] = cursor_enabled;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (apb_setup) begin
            prdata <= next_prdata;
        end
    end

    // Registered panel-side view
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            display_on <= 1'b0;
            power_save_active <= 1'b1;
            block_visible <= '0;
            cursor_visible <= 1'b0;
            cursor_enabled <= 1'b0;
        end else begin
            display_on <= display_live;
            power_save_active <= ps_state != DEAC_PS_ACTIVE;
            cursor_enabled <= attributes[DEAC_ATTR_CUR_LSB+:2] != DEAC_FLASH_BLANK;
            block_visible[0] <= display_live
                && layer_show(attributes[DEAC_ATTR_L1_LSB+:2], flash.fast_on, flash.slow_on);
            block_visible[1] <= display_live
                && layer_show(attributes[DEAC_ATTR_L2_LSB+:2], flash.fast_on, flash.slow_on);
            block_visible[2] <= display_live
                && layer_show(attributes[DEAC_ATTR_L3_LSB+:2], flash.fast_on, flash.slow_on);
            block_visible[3] <= display_live && dual_panel
                && layer_show(attributes[DEAC_ATTR_L2_LSB+:2], flash.fast_on, flash.slow_on);
            cursor_visible <= display_live && layer_show(attributes[DEAC_ATTR_CUR_LSB+:2],
                flash.cursor_vslow_on, flash.cursor_slow_on);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ps_clears_disp: assert property (ps_set_wr |=> !display_enable ##1 !display_on)
        else $error("power save entry left display enabled");
    a_disp_gates_out: assert property (!display_enable |=> block_visible == '0 && !cursor_visible)
        else $error("layer visible while display disabled");
    a_direct_exit_wait: assert property (ps_state == DEAC_PS_SAVE && ps_clr_wr && !indirect_mode
        |=> ps_state == DEAC_PS_PENDING ##1 power_save_active)
        else $error("direct mode exit did not wait for dummy write");
    a_dummy_completes: assert property (ps_state == DEAC_PS_PENDING && apb_wr && !ps_set_wr
        |=> ps_state == DEAC_PS_ACTIVE ##1 !power_save_active)
        else $error("dummy write did not complete power save exit");
    a_ps_enter: assert property (ps_set_wr |=> ps_state == DEAC_PS_SAVE && power_save_bit)
        else $error("power save bit write did not enter power save");
    a_l3_blank: assert property (attributes[DEAC_ATTR_L3_LSB+:2] == DEAC_FLASH_BLANK
        |=> !block_visible[2])
        else $error("third block shown while blanked");
    a_l2_steady: assert property (display_live
        && attributes[DEAC_ATTR_L2_LSB+:2] == DEAC_FLASH_STEADY |=> block_visible[1])
        else $error("second block not shown steadily");
    a_l1_fast: assert property (display_live && attributes[DEAC_ATTR_L1_LSB+:2] == DEAC_FLASH_FAST
        |=> block_visible[0] == $past(flash.fast_on))
        else $error("first block not following fast flash");
    a_dual_share: assert property ($past(dual_panel) |-> block_visible[3] == block_visible[1])
        else $error("fourth block differs from second in dual panel");
    a_cursor_vslow: assert property (display_live
        && attributes[DEAC_ATTR_CUR_LSB+:2] == DEAC_FLASH_FAST
        |=> cursor_visible == $past(flash.cursor_vslow_on))
        else $error("cursor not following slowest flash");
    a_cursor_slow_duty: assert property (!flash.cursor_slow_on |-> !flash.slow_on)
        else $error("cursor off window longer than the layer off half");
    a_write_reenable: assert property (mem_write |-> ##2 cursor_enabled)
        else $error("memory write did not re-enable cursor");
    a_read_advance: assert property (mem_read && !mem_write && !cursor_load
        && !(apb_wr && hit_attr) && !cmd_take
        |=> cursor_addr == $past(cursor_addr) + 1'b1 && $stable(attributes))
        else $error("memory read changed enable or failed to advance");
    a_cmd_loads_attr: assert property (cmd_take && !(apb_wr && hit_attr) && !mem_write
        |=> attributes == $past(cmd_param))
        else $error("display switch command did not load attributes");

    c_ps_exit_direct: cover property (ps_state == DEAC_PS_PENDING ##1 ps_state == DEAC_PS_ACTIVE);
    c_cursor_flash: cover property (cursor_visible ##1 !cursor_visible);
    c_write_wakes: cover property (mem_write && attributes[DEAC_ATTR_CUR_LSB+:2] == DEAC_FLASH_BLANK);
    c_cmd_indirect: cover property (cmd_take);
endmodule
`default_nettype wire

// file: test/deac_apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module deac_apb_host
    import deac_pkg::*;
(
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [DEAC_ADDR_W-1:0] paddr,
    output logic [DEAC_DATA_W-1:0] pwdata,
    input wire logic [DEAC_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic timed_out
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        timed_out = 1'b0;
    end

    // One APB transfer, held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [DEAC_ADDR_W-1:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            timed_out <= 1'b1;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import deac_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, timed_out;
    logic [DEAC_ADDR_W-1:0] paddr;
    logic [DEAC_DATA_W-1:0] pwdata, prdata;
    logic frame_tick, mem_write, mem_read, cursor_load, cmd_display_switch, cmd_display_on;
    logic [DEAC_CURSOR_W-1:0] cursor_load_addr, cursor_addr;
    logic [7:0] cmd_param, rd_val, attr, p, st;
    logic display_on, power_save_active, cursor_visible, cursor_enabled, rd_err, dual;
    logic [3:0] block_visible;
    logic [33:0] exp_q[$];
    int bad_count, total_checks, ticks;
    event sample_ev;

    assign st = {display_on, power_save_active, block_visible, cursor_visible, cursor_enabled};

    deac_display_ctrl u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_tick(frame_tick), .mem_write(mem_write),
        .mem_read(mem_read), .cursor_load(cursor_load), .cursor_load_addr(cursor_load_addr),
        .cmd_display_switch(cmd_display_switch), .cmd_display_on(cmd_display_on),
        .cmd_param(cmd_param), .display_on(display_on), .power_save_active(power_save_active),
        .block_visible(block_visible), .cursor_visible(cursor_visible),
        .cursor_enabled(cursor_enabled), .cursor_addr(cursor_addr));

    deac_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timed_out(timed_out));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Oldest note is compared against what the outputs show now
    always @(sample_ev) begin
        logic [33:0] e;
        e = exp_q.pop_front();
        case (e[33:32])
            2'h0: check({24'h0, st}, e[31:0]);
            2'h1: check({23'h0, rd_err, rd_val}, e[31:0]);
            default: check({16'h0, cursor_addr}, e[31:0]);
        endcase
    end

    task automatic expect_val(input logic [1:0] k, input logic [31:0] v);
        exp_q.push_back({k, v});
        #1;
        -> sample_ev;
        #1;
    endtask

    function automatic logic vis(input logic [1:0] f, input int c, input logic cur);
        case (f)
            DEAC_FLASH_BLANK: vis = 1'b0;
            DEAC_FLASH_STEADY: vis = 1'b1;
            DEAC_FLASH_SLOW: vis = cur ? (c % 32) * 100 < 32 * 70 : c % 32 < 16;
            default: vis = cur ? (c % 64) * 100 < 64 * 70 : c % 4 < 2;
        endcase
    endfunction

    function automatic logic [31:0] exp_st(input logic on, input logic ps, input logic [7:0] a,
                                           input logic dl);
        int c;
        c = ticks % 64;
        exp_st = {24'h0, on, ps, on & dl & vis(a[5:4], c, 1'b0), on & vis(a[7:6], c, 1'b0),
                  on & vis(a[5:4], c, 1'b0), on & vis(a[3:2], c, 1'b0),
                  on & vis(a[1:0], c, 1'b1), a[1:0] != 2'h0};
    endfunction

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, deac_byte_addr(idx), d, rd_val, rd_err);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] v, input logic e);
        u_host.xfer(1'b0, deac_byte_addr(idx), 8'h00, rd_val, rd_err);
        expect_val(2'h1, {23'h0, e, v});
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            frame_tick <= 1'b1;
            @(posedge clk);
            frame_tick <= 1'b0;
        end
        ticks += n;
    endtask

    task automatic mem_pulse(input logic w);
        @(posedge clk);
        mem_write <= w;
        mem_read <= !w;
        @(posedge clk);
        mem_write <= 1'b0;
        mem_read <= 1'b0;
    endtask

    always @(posedge timed_out) begin
        bad_count++;
        final_report;
    end

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        final_report;
    end

    initial begin
        {rst_n, frame_tick, mem_write, mem_read, cursor_load, cmd_display_switch} = '0;
        {cmd_display_on, cmd_param, cursor_load_addr, ticks, bad_count, total_checks} = '0;
        void'($urandom(32'h4597));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        expect_val(2'h0, exp_st(1'b0, 1'b1, 8'h00, 1'b0));
        rd_chk(DEAC_IDX_POWER_SAVE, 8'h01, 1'b0);
        rd_chk(DEAC_IDX_ATTRIBUTES, 8'h00, 1'b0);
        rd_chk(16'h0100, 8'h00, 1'b1);
        // Direct mode: exit stays pending until the next write
        wr(DEAC_IDX_POWER_SAVE, 8'h00);
        settle;
        expect_val(2'h0, exp_st(1'b0, 1'b1, 8'h00, 1'b0));
        rd_chk(DEAC_IDX_STATUS, 8'h03, 1'b0);
        wr(DEAC_IDX_DISPLAY_ON, 8'h01);
        settle;
        expect_val(2'h0, exp_st(1'b1, 1'b0, 8'h00, 1'b0));
        for (int i = 0; i < 16; i++) begin
            attr = i < 4 ? {4{i[1:0]}} : 8'($urandom);
            dual = 1'($urandom);
            wr(DEAC_IDX_CONFIG, {4'h0, dual, 3'h0});
            wr(DEAC_IDX_ATTRIBUTES, attr);
            tick($urandom_range(0, 40));
            settle;
            expect_val(2'h0, exp_st(1'b1, 1'b0, attr, dual));
            rd_chk(DEAC_IDX_ATTRIBUTES, attr, 1'b0);
        end
        wr(DEAC_IDX_ATTRIBUTES, 8'h55);
        wr(DEAC_IDX_DISPLAY_ON, 8'h00);
        settle;
        expect_val(2'h0, exp_st(1'b0, 1'b0, 8'h55, dual));
        wr(DEAC_IDX_DISPLAY_ON, 8'h01);
        wr(DEAC_IDX_POWER_SAVE, 8'h01);
        settle;
        expect_val(2'h0, exp_st(1'b0, 1'b1, 8'h55, dual));
        rd_chk(DEAC_IDX_DISPLAY_ON, 8'h00, 1'b0);
        // Indirect mode: exit completes without a dummy write, display stays off
        wr(DEAC_IDX_CONFIG, 8'h01);
        wr(DEAC_IDX_POWER_SAVE, 8'h00);
        settle;
        expect_val(2'h0, exp_st(1'b0, 1'b0, 8'h55, 1'b0));
        p = {6'($urandom), 2'h0};
        @(posedge clk);
        cmd_display_switch <= 1'b1;
        cmd_display_on <= 1'b1;
        cmd_param <= p;
        @(posedge clk);
        cmd_display_switch <= 1'b0;
        settle;
        expect_val(2'h0, exp_st(1'b1, 1'b0, p, 1'b0));
        rd_chk(DEAC_IDX_ATTRIBUTES, p, 1'b0);
        // Cursor position wraps at the top of memory
        @(posedge clk);
        cursor_load <= 1'b1;
        cursor_load_addr <= 16'hffff;
        @(posedge clk);
        cursor_load <= 1'b0;
        settle;
        expect_val(2'h2, 32'h0000ffff);
        mem_pulse(1'b0);
        settle;
        expect_val(2'h2, 32'h00000000);
        expect_val(2'h0, exp_st(1'b1, 1'b0, p, 1'b0));
        mem_pulse(1'b1);
        settle;
        expect_val(2'h2, 32'h00000001);
        expect_val(2'h0, exp_st(1'b1, 1'b0, {p[7:2], 2'h1}, 1'b0));
        rd_chk(DEAC_IDX_ATTRIBUTES, {p[7:2], 2'h1}, 1'b0);
        wr(16'h0100, 8'hff);
        rd_chk(DEAC_IDX_ATTRIBUTES, {p[7:2], 2'h1}, 1'b0);
        rd_chk(DEAC_IDX_STATUS, 8'h04, 1'b0);
        final_report;
    end
endmodule
`default_nettype wire
